//--- core/flash_spm_pkg.sv
// Constants and types shared by the flash self-programming sequencer
package flash_spm_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] ZLO_OFS  = 4'h1;
  localparam logic [3:0] ZHI_OFS  = 4'h2;
  localparam logic [3:0] DLO_OFS  = 4'h3;
  localparam logic [3:0] DHI_OFS  = 4'h4;
  localparam logic [3:0] LOCK_OFS = 4'h5;

  // Bit positions in self_prog_control_status
  localparam int EN_BIT   = 0;
  localparam int BUSY_BIT = 6;
  localparam int IE_BIT   = 7;

  // Command patterns, low five bits of the control register
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  // Pointer fields: byte select, word_in_page_field, page_field
  localparam int WORD_LSB = 1;
  localparam int WORD_W   = 6;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_W   = 9;
  localparam int PAGE_WORDS = 64;

  // First page of blocking_section; reads of pages below it stall during erase or write
  localparam logic [8:0] BLOCKING_SECTION_FIRST_PAGE = 9'h070;

  // Reset and erased values
  localparam logic [5:0]  LOCK_RST   = 6'h3F;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;

  // Timed-sequence window and operation time
  localparam logic [2:0] WIN_CYC = 3'h4;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int OP_TIME_MIN_NS  = 3700000;
  localparam int OP_TIME_MAX_NS  = 4500000;
  localparam int OP_CYC = (OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W  = 20;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ARMED = 3'h2,
    ST_BUSY  = 3'h4
  } state_t;

endpackage : flash_spm_pkg

//--- core/flash_self_program_sequencer.sv
// Flash self-programming sequencer: timed command window, page buffer, op timer
`timescale 1ns/1ps
module flash_self_program_sequencer
  import flash_spm_pkg::*;
#(
  parameter int unsigned OP_CYCLES = OP_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        spm_exec_i,
  input  wire logic        eeprom_busy_i,
  input  wire logic [15:0] rd_addr_i,
  output logic      [14:0] rd_word_o,
  output logic             rd_byte_hi_o,
  output logic             rd_stall_o,
  output logic             cpu_halt_o,
  output logic             rw_read_block_o,
  output logic             lock_read_block_o,
  output logic             spm_irq_o,
  output logic      [5:0]  lock_bits_o,
  output logic             flash_erase_o,
  output logic             flash_prog_o,
  output logic             flash_lock_o,
  output logic      [8:0]  flash_page_o,
  input  wire logic [5:0]  flash_idx_i,
  output logic      [15:0] flash_wdata_o
);

  localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYCLES - 1);

  state_t      state_ff;
  logic [2:0]  win_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic        ie_ff;
  logic [4:0]  cmd_ff;
  logic        rwbusy_ff;
  logic [15:0] z_ff;
  logic [15:0] dat_ff;
  logic [8:0]  op_page_ff;
  logic [5:0]  op_dat_ff;
  logic        ers_ff;
  logic        prg_ff;
  logic        lck_ff;
  logic        halt_ff;
  logic [5:0]  lock_ff;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [7:0]  rdata_ff;
  logic [14:0] rd_word_ff;
  logic        rd_hi_ff;
  logic        rd_stall_ff;
  logic [15:0] fwd_ff;

  logic wr_ctrl;
  logic arm;
  logic go;
  logic long_op;
  logic done;
  logic expire;
  logic buf_clr;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  function automatic logic in_blocking_section(input logic [8:0] page);
    in_blocking_section = (page >= BLOCKING_SECTION_FIRST_PAGE);
  endfunction : in_blocking_section

  // Control writes, except the IE bit, are dropped while the EEPROM writes or an operation runs
  assign wr_ctrl = we_i && (addr_i == CTRL_OFS) && !eeprom_busy_i
                   && (state_ff != ST_BUSY);
  assign arm = wr_ctrl && wdata_i[EN_BIT];
  assign go = (state_ff == ST_ARMED) && spm_exec_i && !eeprom_busy_i;
  assign long_op = go && ((cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE)
                   || (cmd_ff == CMD_LOCK));
  assign done = (state_ff == ST_BUSY) && (cnt_ff == OP_LAST);
  assign expire = (state_ff == ST_ARMED) && !go && !wr_ctrl
                  && (win_ff == WIN_CYC);
  assign buf_clr = (done && prg_ff) || (go && cmd_ff == CMD_REEN)
                   || eeprom_busy_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (arm)
            state_ff <= ST_ARMED;
        end
        ST_ARMED:
        begin
          if (long_op)
            state_ff <= ST_BUSY;
          else if (go)
            state_ff <= ST_IDLE;
          else if (wr_ctrl && !arm)
            state_ff <= ST_IDLE;
          else if (expire)
            state_ff <= ST_IDLE;
        end
        ST_BUSY:
        begin
          if (done)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Window counts cycles after the control write; a rewrite with EN_BIT set restarts it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      win_ff <= 3'h0;
    else if (arm)
      win_ff <= 3'h1;
    else if (state_ff == ST_ARMED && win_ff != WIN_CYC)
      win_ff <= win_ff + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_ff <= '0;
    else if (state_ff == ST_BUSY)
      cnt_ff <= cnt_ff + CNT_W'(1);
    else
      cnt_ff <= '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ie_ff <= 1'b0;
    else if (we_i && addr_i == CTRL_OFS)
      ie_ff <= wdata_i[IE_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cmd_ff <= 5'h00;
    else if (wr_ctrl)
      cmd_ff <= wdata_i[4:0] & {5{wdata_i[EN_BIT]}};
    else if ((go && !long_op) || expire)
      cmd_ff <= 5'h00;
    else if (done)
      cmd_ff <= 5'h00;
  end

  // Set wins over clear, though both cannot meet: they need different commands
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rwbusy_ff <= 1'b0;
    else if (long_op && cmd_ff != CMD_LOCK)
      rwbusy_ff <= 1'b1;
    else if (go && cmd_ff == CMD_REEN)
      rwbusy_ff <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      z_ff <= 16'h0000;
    else if (we_i && addr_i == ZLO_OFS)
      z_ff[7:0] <= wdata_i;
    else if (we_i && addr_i == ZHI_OFS)
      z_ff[15:8] <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      dat_ff <= 16'h0000;
    else if (we_i && addr_i == DLO_OFS)
      dat_ff[7:0] <= wdata_i;
    else if (we_i && addr_i == DHI_OFS)
      dat_ff[15:8] <= wdata_i;
  end

  // Private copy of address and lock data for the running operation
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      op_page_ff <= 9'h000;
      op_dat_ff  <= LOCK_RST;
    end
    else if (long_op)
    begin
      op_page_ff <= z_ff[PAGE_LSB +: PAGE_W];
      op_dat_ff  <= dat_ff[5:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ers_ff <= 1'b0;
      prg_ff <= 1'b0;
      lck_ff <= 1'b0;
    end
    else if (long_op)
    begin
      ers_ff <= (cmd_ff == CMD_ERASE);
      prg_ff <= (cmd_ff == CMD_WRITE);
      lck_ff <= (cmd_ff == CMD_LOCK);
    end
    else if (done)
    begin
      ers_ff <= 1'b0;
      prg_ff <= 1'b0;
      lck_ff <= 1'b0;
    end
  end

  // Lock setting never halts and never looks at the pointer
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      halt_ff <= 1'b0;
    else if (long_op)
      halt_ff <= (cmd_ff != CMD_LOCK)
                 && in_blocking_section(z_ff[PAGE_LSB +: PAGE_W]);
    else if (done)
      halt_ff <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      lock_ff <= LOCK_RST;
    else if (done && lck_ff)
      lock_ff <= lock_ff & op_dat_ff;
  end

  // Words are indexed only by the word field, so any load order works
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || buf_clr)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_mem[i] <= BUF_ERASED;
    end
    else if (go && cmd_ff == CMD_LOAD)
      buf_mem[z_ff[WORD_LSB +: WORD_W]] <= dat_ff;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      fwd_ff <= BUF_ERASED;
    else
      fwd_ff <= buf_mem[flash_idx_i];
  end

  // Byte reads keep bit zero as the byte select
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_word_ff  <= 15'h0000;
      rd_hi_ff    <= 1'b0;
      rd_stall_ff <= 1'b0;
    end
    else
    begin
      rd_word_ff  <= rd_addr_i[15:1];
      rd_hi_ff    <= rd_addr_i[0];
      rd_stall_ff <= (ers_ff || prg_ff)
                     && !in_blocking_section(rd_addr_i[PAGE_LSB +: PAGE_W]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !re_i)
      rdata_ff <= 8'h00;
    else
    begin
      case (addr_i)
        CTRL_OFS: rdata_ff <= {ie_ff, rwbusy_ff, 1'b0, cmd_ff};
        ZLO_OFS:  rdata_ff <= z_ff[7:0];
        ZHI_OFS:  rdata_ff <= z_ff[15:8];
        DLO_OFS:  rdata_ff <= dat_ff[7:0];
        DHI_OFS:  rdata_ff <= dat_ff[15:8];
        LOCK_OFS: rdata_ff <= eeprom_busy_i ? 8'h00 : {2'h0, lock_ff};
        default:  rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata_o           = rdata_ff;
  assign rd_word_o         = rd_word_ff;
  assign rd_byte_hi_o      = rd_hi_ff;
  assign rd_stall_o        = rd_stall_ff;
  assign cpu_halt_o        = halt_ff;
  assign rw_read_block_o   = ers_ff || prg_ff;
  assign lock_read_block_o = eeprom_busy_i;
  assign spm_irq_o         = ie_ff && !cmd_ff[EN_BIT];
  assign lock_bits_o       = lock_ff;
  assign flash_erase_o     = ers_ff;
  assign flash_prog_o      = prg_ff;
  assign flash_lock_o      = lck_ff;
  assign flash_page_o      = op_page_ff;
  assign flash_wdata_o     = fwd_ff;

  a_page_latch: assert property (
    long_op |=> flash_page_o == $past(z_ff[15:7]))
    else $error("page field not latched at start");

  a_addr_hold: assert property (
    (state_ff == ST_BUSY && $past(state_ff) == ST_BUSY) |-> $stable(flash_page_o))
    else $error("latched page moved during operation");

  a_lock_nohalt: assert property (
    flash_lock_o |-> !cpu_halt_o && !rw_read_block_o)
    else $error("lock programming halted or blocked reads");

  a_halt_target: assert property (
    (long_op && cmd_ff == CMD_ERASE && in_blocking_section(z_ff[15:7])) |=> cpu_halt_o [*8])
    else $error("core not halted for blocking section erase");

  a_window_expiry: assert property (
    expire |=> cmd_ff == 5'h00 && state_ff == ST_IDLE)
    else $error("command bits survived an expired window");

  a_op_length: assert property (
    long_op |=> (state_ff == ST_BUSY) [*8])
    else $error("operation ended too early");

  a_done_clears: assert property (
    done |=> !cmd_ff[EN_BIT] && !flash_erase_o && !flash_prog_o)
    else $error("enable not cleared at completion");

  a_irq_done: assert property (
    (done && ie_ff && !(we_i && addr_i == CTRL_OFS)) |=> spm_irq_o)
    else $error("interrupt missing after completion");

  a_busy_block: assert property (
    rw_read_block_o |-> rwbusy_ff)
    else $error("read block without busy flag");

  a_ee_block: assert property (
    (eeprom_busy_i && state_ff == ST_ARMED) |=> state_ff != ST_BUSY)
    else $error("operation started during eeprom write");

  a_lock_prog: assert property (
    (done && lck_ff) |=> lock_bits_o == ($past(lock_ff) & $past(op_dat_ff)))
    else $error("lock bits not programmed from data");

  a_buf_load: assert property (
    (go && cmd_ff == CMD_LOAD) |=> buf_mem[$past(z_ff[6:1])] == $past(dat_ff))
    else $error("buffer word not loaded");

  a_buf_clear: assert property (
    (done && prg_ff) |=> buf_mem[0] == BUF_ERASED)
    else $error("buffer not cleared after page write");

endmodule : flash_self_program_sequencer

//--- verification/flash_array_model.sv
// Flash array stand-in: walks buffer index during page program and keeps the words
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic        clk_i,
  input  wire logic        erase_i,
  input  wire logic        prog_i,
  input  wire logic        lock_i,
  input  wire logic [15:0] wdata_i,
  output logic      [5:0]  idx_o,
  output logic      [15:0] op_len_o
);
  logic [15:0] page_mem [64];
  logic [5:0]  idx_q  = 6'h00;
  logic [5:0]  idx_d  = 6'h00;
  logic        prog_d = 1'b0;
  logic        act_d  = 1'b0;
  logic [15:0] len_q  = 16'h0000;
  assign idx_o    = idx_q;
  assign op_len_o = len_q;
  always @(posedge clk_i)
  begin
    prog_d <= prog_i;
    idx_d  <= idx_q;
    act_d  <= erase_i | prog_i | lock_i;
    // Buffer word answers one cycle after the index is presented
    if (prog_d)
      page_mem[idx_d] <= wdata_i;
    idx_q <= prog_i ? idx_q + 6'h01 : 6'h00;
    // Length of the most recent operation, restarted on each new one
    if (erase_i | prog_i | lock_i)
      len_q <= act_d ? len_q + 16'h0001 : 16'h0001;
  end
endmodule : flash_array_model

//--- verification/tb_top.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module tb_top;
  import flash_spm_pkg::*;
  localparam int OPC = 20;
  logic clk_i = 1'b0, rst_n_i = 1'b0, we_i = 1'b0, re_i = 1'b0, spm_exec_i = 1'b0;
  logic eeprom_busy_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [15:0] rd_addr_i = 16'h0000, flash_wdata_o, op_len;
  logic [14:0] rd_word_o;
  logic [8:0] flash_page_o;
  logic [5:0] lock_bits_o, flash_idx_i;
  logic rd_byte_hi_o, rd_stall_o, cpu_halt_o, rw_read_block_o, lock_read_block_o;
  logic spm_irq_o, flash_erase_o, flash_prog_o, flash_lock_o;
  int n_mismatch = 0, n_checks = 0;
  always #2 clk_i = ~clk_i;
  flash_self_program_sequencer #(.OP_CYCLES(OPC)) flash_self_program_sequencer_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .spm_exec_i(spm_exec_i), .eeprom_busy_i(eeprom_busy_i),
    .rd_addr_i(rd_addr_i), .rd_word_o(rd_word_o), .rd_byte_hi_o(rd_byte_hi_o),
    .rd_stall_o(rd_stall_o), .cpu_halt_o(cpu_halt_o), .rw_read_block_o(rw_read_block_o),
    .lock_read_block_o(lock_read_block_o), .spm_irq_o(spm_irq_o), .lock_bits_o(lock_bits_o),
    .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o), .flash_lock_o(flash_lock_o),
    .flash_page_o(flash_page_o), .flash_idx_i(flash_idx_i), .flash_wdata_o(flash_wdata_o));
  flash_array_model flash_array_model_inst (
    .clk_i(clk_i), .erase_i(flash_erase_o), .prog_i(flash_prog_o),
    .lock_i(flash_lock_o), .wdata_i(flash_wdata_o), .idx_o(flash_idx_i),
    .op_len_o(op_len));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 chk({8'h00, rdata_o}, {8'h00, exp});
  endtask : rdchk
  // Store pulse lands gap cycles after the control write cycle
  task automatic cmd(input logic [7:0] c, input int gap);
    wr(CTRL_OFS, c);
    repeat (gap - 1) @(posedge clk_i);
    // Nothing interrupts the timed pair, as if interrupts were off
    spm_exec_i <= 1'b1;
    @(posedge clk_i);
    spm_exec_i <= 1'b0;
  endtask : cmd
  task automatic ptr(input logic [7:0] hi, input logic [7:0] lo);
    wr(ZHI_OFS, hi);
    wr(ZLO_OFS, lo);
  endtask : ptr
  task automatic wait_idle();
    // Step off the edge first so freshly launched outputs are settled
    #1;
    for (int k = 0; k < 100 && (flash_erase_o | flash_prog_o | flash_lock_o); k++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk({15'h0, flash_erase_o | flash_prog_o | flash_lock_o}, 16'h0000);
  endtask : wait_idle
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #(5000 * 4);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(CTRL_OFS, 8'h00);
    rdchk(LOCK_OFS, 8'h3F);
    rdchk(4'hF, 8'h00);
    $display("test reset done");
    // Out-of-order loads at window edges, then erase and program a blocking-section page
    wr(DLO_OFS, 8'h5A);
    wr(DHI_OFS, 8'hA5);
    ptr(8'h00, 8'h0A);
    cmd(8'h01, 4);
    wr(DLO_OFS, 8'h34);
    wr(DHI_OFS, 8'h12);
    ptr(8'h00, 8'h04);
    cmd(8'h01, 1);
    ptr(8'h38, 8'h80);
    cmd(8'h03, 1);
    wait_idle();
    cmd(8'h05, 2);
    @(posedge clk_i);
    #1;
    chk({15'h0, cpu_halt_o}, 16'h0001);
    chk({15'h0, flash_prog_o}, 16'h0001);
    chk({7'h0, flash_page_o}, 16'h0071);
    wr(ZHI_OFS, 8'h00);
    chk({7'h0, flash_page_o}, 16'h0071);
    wait_idle();
    chk(op_len, 16'(OPC));
    chk(flash_array_model_inst.page_mem[5], 16'hA55A);
    chk(flash_array_model_inst.page_mem[2], 16'h1234);
    chk(flash_array_model_inst.page_mem[3], 16'hFFFF);
    rdchk(CTRL_OFS, 8'h40);
    $display("test load and write done");
    // Erase a readable-section page: no halt, reads of that section stall
    ptr(8'h10, 8'h00);
    rd_addr_i <= 16'h0101;
    cmd(8'h03, 1);
    @(posedge clk_i);
    #1;
    chk({15'h0, cpu_halt_o}, 16'h0000);
    chk({15'h0, rw_read_block_o}, 16'h0001);
    chk({15'h0, rd_stall_o}, 16'h0001);
    chk({1'b0, rd_word_o}, 16'h0080);
    chk({15'h0, rd_byte_hi_o}, 16'h0001);
    wait_idle();
    chk(op_len, 16'(OPC));
    rdchk(CTRL_OFS, 8'h40);
    cmd(8'h11, 1);
    rdchk(CTRL_OFS, 8'h00);
    $display("test erase done");
    // Store one cycle too late is ignored and the command bits fall
    cmd(8'h03, 5);
    @(posedge clk_i);
    #1;
    chk({15'h0, flash_erase_o}, 16'h0000);
    rdchk(CTRL_OFS, 8'h00);
    $display("test window done");
    // Lock setting with the interrupt enabled; pointer points into the blocking section
    ptr(8'hFF, 8'hFF);
    wr(DLO_OFS, 8'hF5);
    cmd(8'h89, 3);
    @(posedge clk_i);
    #1;
    chk({15'h0, flash_lock_o}, 16'h0001);
    chk({15'h0, cpu_halt_o}, 16'h0000);
    chk({15'h0, spm_irq_o}, 16'h0000);
    wait_idle();
    chk({15'h0, spm_irq_o}, 16'h0001);
    chk({10'h0, lock_bits_o}, 16'h0035);
    rdchk(LOCK_OFS, 8'h35);
    $display("test lock done");
    // EEPROM write discards the buffer and blocks commands and lock reads
    wr(DLO_OFS, 8'h11);
    wr(DHI_OFS, 8'h22);
    ptr(8'h10, 8'h08);
    cmd(8'h01, 1);
    // Busy rises inside an open window, so the store must be refused
    wr(CTRL_OFS, 8'h03);
    eeprom_busy_i <= 1'b1;
    cmd(8'h03, 2);
    @(posedge clk_i);
    #1;
    chk({15'h0, flash_erase_o}, 16'h0000);
    chk({15'h0, lock_read_block_o}, 16'h0001);
    rdchk(LOCK_OFS, 8'h00);
    ptr(8'h10, 8'h00);
    eeprom_busy_i <= 1'b0;
    cmd(8'h05, 1);
    wait_idle();
    chk(flash_array_model_inst.page_mem[4], 16'hFFFF);
    $display("test eeprom done");
    wr(CTRL_OFS, 8'h80);
    #1 chk({15'h0, spm_irq_o}, 16'h0001);
    wr(CTRL_OFS, 8'h00);
    #1 chk({15'h0, spm_irq_o}, 16'h0000);
    $display("test irq done");
    stop_test();
  end
endmodule : tb_top
